/* File: acc_defs.vh */
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
// register indices as printed; byte address is index times four
`define ACC_IDX_CFG_ONE      8'h65
`define ACC_IDX_AVERAGING    8'h68
`define ACC_IDX_STATUS       8'h6A
`define ACC_IDX_PIN_CFG      8'h6B
`define ACC_IDX_SOFT_TRIG    8'h6C
`define ACC_IDX_CFG_ZERO     8'h62
`define ACC_IDX_ENABLE       8'h61
`define ACC_IDX_ENGINE_CMD   8'h70
`define ACC_IDX_IRQ_STATUS   8'h71
`define ACC_IDX_IRQ_ENABLE   8'h72
`define ACC_IDX_IRQ_CLEAR    8'h73
// reset values
`define ACC_RST_CFG_ONE      8'h01
`define ACC_RST_AVERAGING    8'h61
`define ACC_RST_PIN_CFG      8'h00
`define ACC_RST_SOFT_TRIG    8'h01
`define ACC_RST_CFG_ZERO     8'h01
`define ACC_RST_ENABLE       8'h01
// field positions
`define ACC_BIT_OFFSET_REFERENCE_SELECT        2
`define ACC_BIT_BG_EN        1
`define ACC_BIT_FG_EN        0
`define ACC_BIT_TRIG_SEL     0
`define ACC_BIT_SOFT_TRIG    0
`define ACC_BIT_CAL_EN       0
`define ACC_BIT_FOREGROUND_COMPLETE      0
`define ACC_BIT_BG_HALTED    1
`define ACC_BIT_ALARM        2
// status pin sources
`define ACC_PIN_SRC_FG       2'h0
`define ACC_PIN_SRC_HALT     2'h1
`define ACC_PIN_SRC_ALARM    2'h2
`define ACC_PIN_SRC_LOW      2'h3
// cycle limit for foreground run; it ends earlier on engine done
`define ACC_FG_CYCLES        16'h0040
`endif

/* File: acc_sticky.v */
`timescale 1ns/10ps
module acc_sticky
(
    input  wire hclk,
    input  wire hresetn,
    input  wire ce,
    input  wire set_pulse,
    input  wire clr_pulse,
    output reg  flag_r
);
    // set wins over a clear in the same cycle
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flag_r <= 1'b0;
        else if (ce)
            flag_r <= set_pulse | (flag_r & ~clr_pulse);
    end
endmodule // acc_sticky

/* File: acc_ahb_slave.v */
`timescale 1ns/10ps
module acc_ahb_slave
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg         wr_en_r,
    output reg         rd_en_r,
    output reg  [7:0]  idx_r
);
    // capture the address phase; data phase follows in the next cycle
    wire take = hsel & hready & htrans[1] & ce;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_en_r <= 1'b0;
            rd_en_r <= 1'b0;
            idx_r   <= 8'h00;
        end
        else if (ce)
        begin
            wr_en_r <= take & hwrite;
            rd_en_r <= take & ~hwrite;
            if (take)
                idx_r <= haddr[9:2];
        end
    end

    // reads stall one cycle so hrdata comes from a flip-flop; response always OKAY
    assign hreadyout = ~rd_en_r;
    assign hresp     = 1'b0;
endmodule // acc_ahb_slave

/* File: acc_cal_ctrl.v */
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "acc_defs.vh"
// How it works
// - offset reference bit low selects mid-code as offset target
// - offset reference bit high selects spare converter samples as reference
// - offset averaging field bits 6:4, reset 6, drives offset averaging depth
// - linearity averaging field bits 2:0, reset 1, drives linearity averaging
// - background-halted bit sets on stop, clears when calibration resumes
// - without background calibration, halted bit sets when foreground ends
// - foreground-complete bit sets when foreground finishes or is skipped
// - pin source field picks foreground, halted, alarm or constant low
// - trigger select low uses software bit, ignores trigger pin
// - trigger select high uses trigger pin, ignores software bit
// - status register read-only, state code in bits 4:2
// - software trigger bit at 0x6C, reset 1, replaces trigger pin
// - background enable bit runs calibration in background while converting
module acc_cal_ctrl
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        calibration_trigger_pin,
    input  wire        alarm_in,
    input  wire        engine_done,
    input  wire        engine_stopped,
    input  wire        engine_running,
    input  wire [2:0]  engine_state,
    output reg         calibration_status_pin,
    output wire        calibration_trigger,
    output wire        offset_reference_select,
    output wire [2:0]  offset_averaging,
    output wire [2:0]  linearity_averaging,
    output wire        background_cal_enable,
    output wire        foreground_cal_enable,
    output wire        engine_reset_n,
    output wire        engine_stop_req,
    output wire        irq
);
    // engine sequencer states
    localparam ST_HOLD = 2'b00;
    localparam ST_FG   = 2'b01;
    localparam ST_BG   = 2'b10;
    localparam ST_IDLE = 2'b11;

    // decoded bus strobes, high for one cycle in the data phase
    wire       wr_en;
    wire       rd_en;
    wire [7:0] idx;

    // software-visible registers
    reg [7:0]  cfg_one_r;
    reg [7:0]  averaging_r;
    reg [7:0]  pin_cfg_r;
    reg [7:0]  soft_trig_r;
    reg [7:0]  cfg_zero_r;
    reg [7:0]  enable_r;
    reg        stop_req_r;
    reg [2:0]  irq_en_r;
    // sequencer and status flags
    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [15:0] fg_cnt_r;
    reg        foreground_complete_r;
    reg        halted_r;
    reg [2:0]  stat_code_r;
    reg        stat_valid_r;
    // last-cycle copies for edge detection
    reg        prev_halted_r;
    reg        prev_fg_r;
    reg        prev_alarm_r;
    // read mux output, loaded into hrdata
    reg [31:0] rdata_nxt;

    // interrupt status, set and clear vectors
    wire [2:0] irq_stat;
    wire [2:0] irq_set;
    wire [2:0] irq_clr;
    // enable bit, doubles as the engine's active-low reset
    wire       cal_en;

    acc_ahb_slave u_bus
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr_en_r   (wr_en),
        .rd_en_r   (rd_en),
        .idx_r     (idx)
    );

    // writable configuration; reserved bits of the 8-bit registers stored as written
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_one_r   <= `ACC_RST_CFG_ONE;
            averaging_r <= `ACC_RST_AVERAGING;
            pin_cfg_r   <= `ACC_RST_PIN_CFG;
            soft_trig_r <= `ACC_RST_SOFT_TRIG;
            cfg_zero_r  <= `ACC_RST_CFG_ZERO;
            enable_r    <= `ACC_RST_ENABLE;
            stop_req_r  <= 1'b0;
            irq_en_r    <= 3'h0;
        end
        else if (ce && wr_en)
        begin
            case (idx)
                `ACC_IDX_CFG_ONE:    cfg_one_r   <= hwdata[7:0];
                `ACC_IDX_AVERAGING:  averaging_r <= hwdata[7:0];
                `ACC_IDX_PIN_CFG:    pin_cfg_r   <= hwdata[7:0];
                `ACC_IDX_SOFT_TRIG:  soft_trig_r <= hwdata[7:0];
                `ACC_IDX_CFG_ZERO:   cfg_zero_r  <= hwdata[7:0];
                `ACC_IDX_ENABLE:     enable_r    <= hwdata[7:0];
                `ACC_IDX_ENGINE_CMD: stop_req_r  <= hwdata[0];
                `ACC_IDX_IRQ_ENABLE: irq_en_r    <= hwdata[2:0];
                default:             stop_req_r  <= stop_req_r;
            endcase
        end
    end

    // engine control outputs; clearing the enable bit holds the engine in reset
    assign cal_en                  = enable_r[`ACC_BIT_CAL_EN];
    assign engine_reset_n          = cal_en;
    assign engine_stop_req         = stop_req_r;
    // 0 = mid-code target, 1 = spare converter reference
    assign offset_reference_select = cfg_one_r[`ACC_BIT_OFFSET_REFERENCE_SELECT];
    assign offset_averaging        = averaging_r[6:4];
    assign linearity_averaging     = averaging_r[2:0];
    assign background_cal_enable   = cfg_zero_r[`ACC_BIT_BG_EN];
    assign foreground_cal_enable   = cfg_zero_r[`ACC_BIT_FG_EN];

    // trigger mux; the unused source is fully ignored
    assign calibration_trigger = pin_cfg_r[`ACC_BIT_TRIG_SEL] ? calibration_trigger_pin
                                                               : soft_trig_r[`ACC_BIT_SOFT_TRIG];

    // sequencer: hold while disabled, run or skip foreground, then background if enabled, else idle
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_HOLD: state_nxt = cal_en ? ST_FG : ST_HOLD;
            ST_FG:
            begin
                if (!foreground_cal_enable || engine_done || fg_cnt_r == `ACC_FG_CYCLES)
                    state_nxt = background_cal_enable ? ST_BG : ST_IDLE;
            end
            ST_BG:   state_nxt = background_cal_enable ? ST_BG : ST_IDLE;
            ST_IDLE: state_nxt = ST_IDLE;
            default: state_nxt = ST_HOLD;
        endcase
        if (!cal_en)
            state_nxt = ST_HOLD;
    end

    // status flags; engine in reset clears them so no stale completion shows
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r      <= ST_HOLD;
            fg_cnt_r     <= 16'h0000;
            foreground_complete_r    <= 1'b0;
            halted_r     <= 1'b0;
            stat_code_r  <= 3'h0;
            stat_valid_r <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            if (!cal_en)
            begin
                foreground_complete_r    <= 1'b0;
                halted_r     <= 1'b0;
                fg_cnt_r     <= 16'h0000;
                stat_valid_r <= 1'b0;
            end
            else
            begin
                fg_cnt_r <= (state_r == ST_FG) ? fg_cnt_r + 16'h0001 : 16'h0000;
                if (state_r == ST_FG && state_nxt != ST_FG)
                    foreground_complete_r <= 1'b1;
                if (state_r == ST_FG && state_nxt == ST_IDLE)
                    halted_r <= 1'b1;
                else if (state_r == ST_BG)
                begin
                    if (stop_req_r && engine_stopped)
                        halted_r <= 1'b1;
                    else if (engine_running)
                        halted_r <= 1'b0;
                end
                stat_code_r  <= engine_state;
                stat_valid_r <= 1'b1;
            end
        end
    end

    // rising edges of the three events feed the interrupt flags
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_fg_r     <= 1'b0;
            prev_halted_r <= 1'b0;
            prev_alarm_r  <= 1'b0;
        end
        else if (ce)
        begin
            prev_fg_r     <= foreground_complete_r;
            prev_halted_r <= halted_r;
            prev_alarm_r  <= alarm_in;
        end
    end

    // rising edges only, so a level held high raises each flag once
    assign irq_set = {alarm_in & ~prev_alarm_r, halted_r & ~prev_halted_r, foreground_complete_r & ~prev_fg_r};
    assign irq_clr = (wr_en && idx == `ACC_IDX_IRQ_CLEAR) ? hwdata[2:0] : 3'h0;

    // one sticky flag per event; a set in the same cycle as a clear wins
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_irq
            acc_sticky u_flag
            (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .ce        (ce),
                .set_pulse (irq_set[gi]),
                .clr_pulse (irq_clr[gi]),
                .flag_r    (irq_stat[gi])
            );
        end
    endgenerate

    // level interrupt, high while any enabled flag stands
    assign irq = |(irq_stat & irq_en_r);

    // status pin source select
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            calibration_status_pin <= 1'b0;
        else if (ce)
        begin
            case (pin_cfg_r[2:1])
                `ACC_PIN_SRC_FG:    calibration_status_pin <= foreground_complete_r;
                `ACC_PIN_SRC_HALT:  calibration_status_pin <= halted_r;
                `ACC_PIN_SRC_ALARM: calibration_status_pin <= alarm_in;
                default:            calibration_status_pin <= 1'b0;
            endcase
        end
    end

    // read mux; status is read-only, writes to it are dropped
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        case (idx)
            `ACC_IDX_CFG_ONE:    rdata_nxt[7:0] = cfg_one_r;
            `ACC_IDX_AVERAGING:  rdata_nxt[7:0] = averaging_r;
            `ACC_IDX_STATUS:     rdata_nxt[4:0] = {stat_valid_r ? stat_code_r : 3'h0, halted_r, foreground_complete_r};
            `ACC_IDX_PIN_CFG:    rdata_nxt[7:0] = pin_cfg_r;
            `ACC_IDX_SOFT_TRIG:  rdata_nxt[7:0] = soft_trig_r;
            `ACC_IDX_CFG_ZERO:   rdata_nxt[7:0] = cfg_zero_r;
            `ACC_IDX_ENABLE:     rdata_nxt[7:0] = enable_r;
            `ACC_IDX_ENGINE_CMD: rdata_nxt[0]   = stop_req_r;
            `ACC_IDX_IRQ_STATUS: rdata_nxt[2:0] = irq_stat;
            `ACC_IDX_IRQ_ENABLE: rdata_nxt[2:0] = irq_en_r;
            default:             rdata_nxt      = 32'h0000_0000;
        endcase
    end

    // cleared when a read is taken, loaded at the end of its wait state
    // a stall per read was traded for no bypass path on read-after-write
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (ce && hsel && hready && htrans[1] && !hwrite)
            hrdata <= 32'h0000_0000;
        else if (ce && rd_en)
            hrdata <= rdata_nxt;
    end
endmodule // acc_cal_ctrl

/* File: acc_cal_ctrl_monitor.sv */
`timescale 1ns/10ps
module acc_cal_ctrl_monitor
(
    input wire        hclk,
    input wire        hresetn,
    input wire        ce,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire        calibration_trigger_pin,
    input wire        calibration_status_pin,
    input wire        calibration_trigger,
    input wire        offset_reference_select,
    input wire [2:0]  offset_averaging,
    input wire [2:0]  linearity_averaging,
    input wire        background_cal_enable,
    input wire        engine_reset_n
);
    reg       wr_r;
    reg [7:0] idx_r;
    reg [2:0] pcfg_r;
    reg       soft_r;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // shadow of the two pin registers, rebuilt from bus writes
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_r   <= 1'b0;
            idx_r  <= 8'h00;
            pcfg_r <= 3'h0;
            soft_r <= 1'b1;
        end
        else
        begin
            wr_r  <= hsel && hready && htrans[1] && hwrite && ce;
            idx_r <= haddr[9:2];
            if (wr_r && idx_r == 8'h6B) pcfg_r <= hwdata[2:0];
            if (wr_r && idx_r == 8'h6C) soft_r <= hwdata[0];
        end
    end
    property p_trig_soft; !pcfg_r[0] |-> calibration_trigger == soft_r; endproperty
    a_trig_soft: assert property (p_trig_soft) else $error("trigger not from soft bit");
    property p_trig_pin; pcfg_r[0] |-> calibration_trigger == calibration_trigger_pin; endproperty
    a_trig_pin: assert property (p_trig_pin) else $error("trigger not from pin");
    property p_pin_low; (pcfg_r[2:1] == 2'h3) [*2] |-> !calibration_status_pin; endproperty
    a_pin_low: assert property (p_pin_low) else $error("status pin not held low");
    property p_ofs_ref; wr_r && idx_r == 8'h65 |=> offset_reference_select == $past(hwdata[2]); endproperty
    a_ofs_ref: assert property (p_ofs_ref) else $error("offset reference mismatch");
    property p_ofs_avg; wr_r && idx_r == 8'h68 |=> offset_averaging == $past(hwdata[6:4]); endproperty
    a_ofs_avg: assert property (p_ofs_avg) else $error("offset averaging mismatch");
    property p_lin_avg; wr_r && idx_r == 8'h68 |=> linearity_averaging == $past(hwdata[2:0]); endproperty
    a_lin_avg: assert property (p_lin_avg) else $error("linearity averaging mismatch");
    property p_soft; wr_r && idx_r == 8'h6C && !pcfg_r[0] |=> calibration_trigger == $past(hwdata[0]); endproperty
    a_soft: assert property (p_soft) else $error("soft trigger write lost");
    property p_bg_en; wr_r && idx_r == 8'h62 |=> background_cal_enable == $past(hwdata[1]); endproperty
    a_bg_en: assert property (p_bg_en) else $error("background enable mismatch");
    property p_hold; (!engine_reset_n && pcfg_r[2:1] == 2'h0) [*3] |-> !calibration_status_pin; endproperty
    a_hold: assert property (p_hold) else $error("completion seen in reset");
endmodule // acc_cal_ctrl_monitor
bind acc_cal_ctrl acc_cal_ctrl_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .calibration_trigger_pin(calibration_trigger_pin), .calibration_status_pin(calibration_status_pin),
    .calibration_trigger(calibration_trigger), .offset_reference_select(offset_reference_select),
    .offset_averaging(offset_averaging), .linearity_averaging(linearity_averaging),
    .background_cal_enable(background_cal_enable), .engine_reset_n(engine_reset_n));

/* File: acc_engine_model.sv */
`timescale 1ns/10ps
module acc_engine_model
#(
    parameter int       DONE_DLY   = 20,
    parameter bit [2:0] STATE_CODE = 3'h5
)
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        engine_reset_n,
    input  wire        foreground_cal_enable,
    input  wire        engine_stop_req,
    output logic       engine_done,
    output logic       engine_stopped,
    output wire        engine_running,
    output wire  [2:0] engine_state
);
    int cnt;
    // finishes well inside the 64-cycle limit so the done path is used
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn || !engine_reset_n)
        begin
            cnt <= 0;
            engine_done <= 1'b0;
            engine_stopped <= 1'b0;
        end
        else
        begin
            if (foreground_cal_enable && !engine_done) cnt <= cnt + 1;
            if (cnt == DONE_DLY) engine_done <= 1'b1;
            engine_stopped <= engine_stop_req;
        end
    end
    assign engine_running = engine_reset_n && !engine_stopped;
    assign engine_state = STATE_CODE; // arbitrary code
endmodule // acc_engine_model

/* File: acc_cal_ctrl_tb_top.sv */
`timescale 1ns/10ps
module acc_cal_ctrl_tb_top;
    logic hclk, hresetn, hsel, hwrite, trig_pin, alarm_in;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [7:0] v;
    wire [31:0] hrdata;
    wire hresp;
    wire [2:0] oavg, lavg, est;
    wire hreadyout, stat_pin, cal_trig, oref, bg_en, fg_en, eng_rst_n, stop_req, irq, e_done, e_stop, e_run;
    int error_cnt = 0;
    int n_tests = 0;
    logic [10:0] exp_q[$];
    event obs_ev;
    acc_cal_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .calibration_trigger_pin(trig_pin),
        .alarm_in(alarm_in), .engine_done(e_done), .engine_stopped(e_stop), .engine_running(e_run),
        .engine_state(est), .calibration_status_pin(stat_pin), .calibration_trigger(cal_trig),
        .offset_reference_select(oref), .offset_averaging(oavg), .linearity_averaging(lavg),
        .background_cal_enable(bg_en), .foreground_cal_enable(fg_en), .engine_reset_n(eng_rst_n),
        .engine_stop_req(stop_req), .irq(irq));
    acc_engine_model eng_u (.hclk(hclk), .hresetn(hresetn), .engine_reset_n(eng_rst_n),
        .foreground_cal_enable(fg_en), .engine_stop_req(stop_req), .engine_done(e_done),
        .engine_stopped(e_stop), .engine_running(e_run), .engine_state(est));
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    task end_sim;
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one bus transfer; hreadyout is the bus ready
    task xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, i, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (!hreadyout);
    endtask
    // note an expectation; watcher samples the selected output
    task ex(input logic [2:0] s, input logic [7:0] e);
        @(posedge hclk);
        exp_q.push_back({s, e});
        ->obs_ev;
    endtask
    // read data is noted at the edge that ends the data phase
    task rd(input logic [7:0] i, input logic [7:0] e);
        xfer(1'b0, i, 8'h00);
        exp_q.push_back({3'h0, e});
        ->obs_ev;
    endtask
    // status pin is registered behind registered flags, so let it settle
    task pin(input logic [7:0] e);
        repeat (3) @(posedge hclk);
        ex(3'h1, e);
    endtask
    // watcher compares the output named by the oldest note's selector
    always @(obs_ev)
    begin
        case (exp_q[0][10:8])
            3'h0:
            begin
                chk(hrdata[7:0], exp_q[0][7:0]);
                chk({7'h0, hresp}, 8'h00);
            end
            3'h1: chk({7'h0, stat_pin}, exp_q[0][7:0]);
            3'h2: chk({7'h0, cal_trig}, exp_q[0][7:0]);
            3'h3: chk({1'b0, oavg, oref, lavg}, exp_q[0][7:0]);
            default: chk({7'h0, irq}, exp_q[0][7:0]);
        endcase
        void'(exp_q.pop_front());
    end
    initial
    begin
        repeat (5000) @(posedge hclk);
        error_cnt++;
        end_sim;
    end
    initial
    begin
        {hresetn, hsel, hwrite, trig_pin, alarm_in, htrans, haddr, hwdata} = '0;
        void'($urandom(32'h2b57));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h65, 8'h01);
        rd(8'h68, 8'h61);
        rd(8'h6B, 8'h00);
        rd(8'h6C, 8'h01);
        ex(3'h3, 8'h61);
        ex(3'h2, 8'h01);
        repeat (30) @(posedge hclk);
        rd(8'h6A, 8'h17);
        xfer(1'b1, 8'h6A, 8'hFF);
        rd(8'h6A, 8'h17);
        rd(8'hFF, 8'h00);
        v = 8'h77 & $urandom;
        xfer(1'b1, 8'h68, v);
        rd(8'h68, v);
        ex(3'h3, v);
        xfer(1'b1, 8'h62, 8'h03);
        xfer(1'b1, 8'h65, 8'h05);
        ex(3'h3, v | 8'h08);
        xfer(1'b1, 8'h65, 8'h01);
        ex(3'h3, v);
        for (int k = 0; k < 8; k++)
        begin
            xfer(1'b1, 8'h6B, {7'h0, k[2]});
            xfer(1'b1, 8'h6C, {7'h0, k[1]});
            trig_pin <= k[0];
            ex(3'h2, {7'h0, k[2] ? k[0] : k[1]});
        end
        xfer(1'b1, 8'h6C, 8'h01);
        for (int s = 0; s < 4; s++)
        begin
            xfer(1'b1, 8'h6B, {5'h0, s[1:0], 1'b0});
            pin({7'h0, s < 2});
        end
        alarm_in <= 1'b1;
        xfer(1'b1, 8'h6B, 8'h04);
        pin(8'h01);
        rd(8'h71, 8'h07);
        ex(3'h4, 8'h00);
        xfer(1'b1, 8'h72, 8'h04);
        ex(3'h4, 8'h01);
        xfer(1'b1, 8'h73, 8'h03);
        rd(8'h71, 8'h04);
        xfer(1'b1, 8'h72, 8'h00);
        ex(3'h4, 8'h00);
        xfer(1'b1, 8'h72, 8'h04);
        xfer(1'b1, 8'h73, 8'h04);
        rd(8'h71, 8'h00);
        ex(3'h4, 8'h00);
        xfer(1'b1, 8'h6B, 8'h00);
        xfer(1'b1, 8'h61, 8'h00);
        pin(8'h00);
        xfer(1'b1, 8'h62, 8'h02);
        xfer(1'b1, 8'h61, 8'h01);
        pin(8'h01);
        xfer(1'b1, 8'h6B, 8'h02);
        pin(8'h00);
        xfer(1'b1, 8'h70, 8'h01);
        repeat (4) @(posedge hclk);
        ex(3'h1, 8'h01);
        xfer(1'b1, 8'h70, 8'h00);
        repeat (4) @(posedge hclk);
        ex(3'h1, 8'h00);
        @(posedge hclk);
        end_sim;
    end
endmodule // acc_cal_ctrl_tb_top
